//--- hdl/isp_host.sv
`timescale 1ns/10ps
`default_nettype none
// Programmer side of the serial programming port
module isp_host
#(
  parameter int PWRUP_CYC = isp_pkg::PWRUP_WAIT_CYC,
  parameter int FLASH_CYC = isp_pkg::FLASH_WAIT_CYC,
  parameter int EEPROM_CYC = isp_pkg::EEPROM_WAIT_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic session,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_word,
  input wire logic use_poll,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_echo_ok,
  output logic in_session,
  output logic sync_fail,
  output logic tgt_reset_n,
  output logic tgt_sck,
  output logic tgt_mosi,
  input wire logic tgt_miso
);
  typedef enum logic [2:0] {
    ISP_OFF, ISP_PULSE, ISP_PWRUP, ISP_IDLE, ISP_SEND, ISP_WAIT
  } isp_st_e;

  isp_shift_if sh ();
  isp_st_e st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] word_reg, word_next;
  logic [1:0] idx_reg, idx_next;
  logic busy_reg, busy_next;
  logic echo_reg, echo_next;
  logic enabled_reg, enabled_next;
  logic poll_reg, poll_next;
  logic [31:0] wait_reg, wait_next;
  logic rdy_reg, rdy_next, rv_reg, rv_next, ok_reg, ok_next;
  logic fail_reg, fail_next, rstn_reg, rstn_next;
  logic [7:0] rd_reg, rd_next;
  logic miso_m, miso_s;

  // Two flops on the target data line before anything reads it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end
    else
    begin
      miso_m <= tgt_miso;
      miso_s <= miso_m;
    end
  end

  isp_byte_shift u_shift (
    .mclk(mclk),
    .rst_n(rst_n),
    .sh(sh.slave),
    .miso_sync(miso_s),
    .sck(tgt_sck),
    .mosi(tgt_mosi)
  );

  assign sh.start = busy_reg && (st_reg == ISP_SEND) && !sh.done && (cnt_reg == 32'h0);
  assign sh.tx = word_reg[31:24];

  // Session sequencer
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    idx_next = idx_reg;
    busy_next = busy_reg;
    echo_next = echo_reg;
    enabled_next = enabled_reg;
    poll_next = poll_reg;
    wait_next = wait_reg;
    rdy_next = 1'b0;
    rv_next = 1'b0;
    ok_next = ok_reg;
    fail_next = fail_reg;
    rstn_next = rstn_reg;
    rd_next = rd_reg;
    unique case (st_reg)
      ISP_OFF:
      begin
        rstn_next = 1'b1; // Released reset means normal target run
        enabled_next = 1'b0;
        if (session)
        begin
          // Clock already low; pulse reset high then low
          cnt_next = 32'(isp_pkg::RST_PULSE_CYC);
          st_next = ISP_PULSE;
        end
      end
      ISP_PULSE:
      begin
        cnt_next = cnt_reg - 32'h1;
        if (cnt_reg == 32'h1)
        begin
          rstn_next = 1'b0; // Session only under low reset
          cnt_next = 32'(PWRUP_CYC);
          st_next = ISP_PWRUP;
        end
      end
      ISP_PWRUP:
      begin
        cnt_next = cnt_reg - 32'h1;
        if (cnt_reg == 32'h1)
        begin
          // First instruction after the delay is programming enable
          word_next = {isp_pkg::OP_ENABLE_B1, isp_pkg::OP_ENABLE_B2, 16'h0000};
          idx_next = 2'h0;
          busy_next = 1'b1;
          cnt_next = 32'h0;
          wait_next = 32'h0;
          st_next = ISP_SEND;
        end
      end
      ISP_IDLE:
      begin
        // Ready stays up until a command is taken, so a held request is never starved
        rdy_next = session && !(cmd_valid && cmd_ready);
        if (!session)
        begin
          st_next = ISP_OFF;
        end
        else if (cmd_valid && cmd_ready)
        begin
          word_next = cmd_word; // Sent as given, so load order is the caller's
          idx_next = 2'h0;
          busy_next = 1'b1;
          poll_next = use_poll;
          cnt_next = 32'h0;
          // Writes and erase need their delay when not polling
          if (cmd_word[31:24] == isp_pkg::OP_WR_FLASH_PAGE) // Page commit
            wait_next = 32'(FLASH_CYC);
          else if (cmd_word[31:24] == isp_pkg::OP_WR_EEPROM
                   || cmd_word[31:24] == isp_pkg::OP_WR_EEPROM_PAGE)
            wait_next = 32'(EEPROM_CYC); // Page and byte commits
          else if (cmd_word[31:24] == isp_pkg::OP_FUSE_GROUP
                   && cmd_word[23:16] == isp_pkg::OP_ERASE_B2)
            wait_next = 32'(EEPROM_CYC);
          else if (cmd_word[31:24] == isp_pkg::OP_FUSE_GROUP
                   && cmd_word[23:16] != isp_pkg::OP_ENABLE_B2)
            wait_next = 32'(FLASH_CYC);
          else
            wait_next = 32'h0;
          st_next = ISP_SEND;
        end
      end
      ISP_SEND:
      begin
        if (sh.done)
        begin
          word_next = {word_reg[23:0], 8'h00};
          idx_next = idx_reg + 2'h1;
          // Echo of 0x53 arrives while the third byte shifts
          if (idx_reg == 2'h2)
            echo_next = (sh.rx == isp_pkg::OP_ENABLE_B2);
          if (idx_reg == 2'h3)
          begin
            busy_next = 1'b0;
            rd_next = sh.rx; // Read data arrives in the fourth byte
            if (!enabled_reg)
            begin
              // Four bytes sent regardless; retry with a reset pulse
              if (echo_reg)
              begin
                enabled_next = 1'b1;
                st_next = ISP_IDLE;
              end
              else
              begin
                fail_next = 1'b1;
                rstn_next = 1'b1;
                cnt_next = 32'(isp_pkg::RST_PULSE_CYC);
                st_next = ISP_PULSE;
              end
            end
            else
            begin
              rv_next = 1'b1;
              ok_next = echo_reg;
              cnt_next = poll_reg ? 32'h0 : wait_reg;
              st_next = (poll_reg || wait_reg == 32'h0) ? ISP_IDLE : ISP_WAIT;
            end
          end
        end
      end
      ISP_WAIT:
      begin
        cnt_next = cnt_reg - 32'h1; // Host stays off the link meanwhile
        if (cnt_reg <= 32'h1)
          st_next = ISP_IDLE;
      end
      default: st_next = ISP_OFF;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_reg <= ISP_OFF;
      cnt_reg <= 32'h0;
      word_reg <= 32'h0;
      idx_reg <= 2'h0;
      busy_reg <= 1'b0;
      echo_reg <= 1'b0;
      enabled_reg <= 1'b0;
      poll_reg <= 1'b0;
      wait_reg <= 32'h0;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      ok_reg <= 1'b0;
      fail_reg <= 1'b0;
      rstn_reg <= 1'b1;
      rd_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      idx_reg <= idx_next;
      busy_reg <= busy_next;
      echo_reg <= echo_next;
      enabled_reg <= enabled_next;
      poll_reg <= poll_next;
      wait_reg <= wait_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      ok_reg <= ok_next;
      fail_reg <= fail_next;
      rstn_reg <= rstn_next;
      rd_reg <= rd_next;
    end
  end

  // Outputs straight from flops
  assign cmd_ready = rdy_reg;
  assign rsp_valid = rv_reg;
  assign rsp_data = rd_reg;
  assign rsp_echo_ok = ok_reg;
  assign in_session = enabled_reg;
  assign sync_fail = fail_reg;
  assign tgt_reset_n = rstn_reg;
endmodule // isp_host
`default_nettype wire

//--- hdl/isp_pkg.sv
package isp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int SCK_HALF_NS = 62;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ) / 1000;
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PWRUP_WAIT_MS = 20;
  localparam int PWRUP_WAIT_CYC = PWRUP_WAIT_MS * CLK_MHZ * 1000;
  localparam int FLASH_WAIT_US = 4500;
  localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
  localparam int EEPROM_WAIT_US = 9000;
  localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * CLK_MHZ;
  localparam logic [7:0] OP_ENABLE_B1 = 8'hac;
  localparam logic [7:0] OP_ENABLE_B2 = 8'h53;
  localparam logic [7:0] OP_ERASE_B2 = 8'h80;
  localparam logic [7:0] OP_POLL = 8'hf0;
  localparam logic [7:0] OP_WR_FLASH_PAGE = 8'h4c;
  localparam logic [7:0] OP_WR_EEPROM = 8'hc0;
  localparam logic [7:0] OP_WR_EEPROM_PAGE = 8'hc2;
  localparam logic [7:0] OP_FUSE_GROUP = 8'hac;
  // Which wait applies after an instruction
  typedef enum logic [1:0] {ISP_WAIT_NONE, ISP_WAIT_FLASH, ISP_WAIT_EEPROM} isp_wait_e;
endpackage

//--- hdl/isp_shift_if.sv
`timescale 1ns/10ps
`default_nettype none
// Byte shifter handshake between the sequencer and the bit engine
interface isp_shift_if;
  logic start;
  logic [7:0] tx;
  logic [7:0] rx;
  logic done;
  modport master (output start, output tx, input rx, input done);
  modport slave (input start, input tx, output rx, output done);
endinterface
`default_nettype wire

//--- hdl/isp_byte_shift.sv
`timescale 1ns/10ps
`default_nettype none
// Shifts one byte msb first, clock idles low
module isp_byte_shift
(
  input wire logic mclk,
  input wire logic rst_n,
  isp_shift_if.slave sh,
  input wire logic miso_sync,
  output logic sck,
  output logic mosi
);
  typedef enum logic [1:0] {ISP_SH_IDLE, ISP_SH_LOW, ISP_SH_HIGH} isp_sh_e;
  isp_sh_e st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] tx_reg, tx_next, rx_reg, rx_next;
  logic done_reg, done_next;

  // Half periods well above three target cycles even at high target clocks
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    done_next = 1'b0;
    unique case (st_reg)
      ISP_SH_IDLE:
      begin
        if (sh.start)
        begin
          tx_next = sh.tx;
          bit_next = 3'h7;
          cnt_next = 8'h00;
          st_next = ISP_SH_LOW;
        end
      end
      ISP_SH_LOW:
      begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(isp_pkg::SCK_HALF_CYC - 1))
        begin
          cnt_next = 8'h00;
          st_next = ISP_SH_HIGH; // Target samples mosi on this rise
        end
      end
      ISP_SH_HIGH:
      begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(isp_pkg::SCK_HALF_CYC - 1))
        begin
          cnt_next = 8'h00;
          // Sample miso just before the fall, it changes on the fall
          rx_next = {rx_reg[6:0], miso_sync};
          tx_next = {tx_reg[6:0], 1'b0}; // Msb first
          bit_next = bit_reg - 3'h1;
          if (bit_reg == 3'h0)
          begin
            st_next = ISP_SH_IDLE;
            done_next = 1'b1;
          end
          else
          begin
            st_next = ISP_SH_LOW;
          end
        end
      end
      default: st_next = ISP_SH_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_reg <= ISP_SH_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      done_reg <= done_next;
    end
  end

  // Registered pins; clock only high in the high phase
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sck <= 1'b0;
      mosi <= 1'b0;
    end
    else
    begin
      sck <= (st_next == ISP_SH_HIGH);
      mosi <= tx_next[7];
    end
  end

  assign sh.rx = rx_reg;
  assign sh.done = done_reg;
endmodule // isp_byte_shift
`default_nettype wire

//--- verif/isp_host_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Pin-level checks on the programmer side of the link
module isp_host_asserts
#(
  parameter int PWRUP_CYC = 50,
  parameter int FLASH_CYC = 40,
  parameter int EEPROM_CYC = 80
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic session,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_word,
  input wire logic use_poll,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_echo_ok,
  input wire logic in_session,
  input wire logic sync_fail,
  input wire logic tgt_reset_n,
  input wire logic tgt_sck,
  input wire logic tgt_mosi,
  input wire logic tgt_miso
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Clock levels must outlast the target's two-flop sampler
  a_sck_in_reset: assert property (tgt_sck |-> !tgt_reset_n)
    else $error("link clock outside programming mode");
  a_ready_after_enable: assert property (cmd_ready |-> in_session && !tgt_reset_n)
    else $error("command accepted before enable");
  a_sck_high_len: assert property ($rose(tgt_sck) |-> tgt_sck[*6] ##1 !tgt_sck)
    else $error("link clock high phase wrong");
  a_sck_low_len: assert property ($fell(tgt_sck) |-> !tgt_sck[*3])
    else $error("link clock low phase too short");
  a_mosi_hold_high: assert property (tgt_sck && $past(tgt_sck) |-> $stable(tgt_mosi))
    else $error("data out moved while clock high");
  a_reset_pulse_len: assert property ($rose(tgt_reset_n) && session |-> tgt_reset_n[*2])
    else $error("target reset pulse too short");
  a_pwrup_quiet: assert property ($fell(tgt_reset_n) |-> !tgt_sck[*8])
    else $error("link clock right after reset entry");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe longer than a cycle");
  a_fail_sticky: assert property (sync_fail |=> sync_fail)
    else $error("sync failure flag dropped");
endmodule // isp_host_asserts
bind isp_host isp_host_asserts #(.PWRUP_CYC(PWRUP_CYC), .FLASH_CYC(FLASH_CYC),
  .EEPROM_CYC(EEPROM_CYC)) chk_u (.mclk(mclk), .rst_n(rst_n), .session(session),
  .cmd_valid(cmd_valid), .cmd_word(cmd_word), .use_poll(use_poll), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_echo_ok(rsp_echo_ok),
  .in_session(in_session), .sync_fail(sync_fail), .tgt_reset_n(tgt_reset_n),
  .tgt_sck(tgt_sck), .tgt_mosi(tgt_mosi), .tgt_miso(tgt_miso));
`default_nettype wire

//--- verif/isp_tgt_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural target; skew high forces a wrong echo byte
module isp_tgt_model
#(
  parameter int BUSY_CYC = 350
)
(
  input wire logic mclk,
  input wire logic tgt_reset_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic skew,
  output logic miso
);
  logic [2:0] sy = 3'h0;
  logic [4:0] n = 5'h00;
  logic [30:0] sh;
  logic [7:0] out;
  logic [15:0] fl [256];
  logic [15:0] pb [64];
  logic [7:0] ee [16];
  logic [7:0] eb [4];
  logic [3:0] ev = 4'h0;
  logic en = 1'b0;
  int busy = 0;
  wire logic [31:0] x = {sh, mosi};
  wire logic rise = sy[1] && !sy[2];
  wire logic fall = !sy[1] && sy[2];
  initial miso = 1'b0;
  // Byte out during the last byte
  function automatic logic [7:0] rd(input logic [23:0] w);
    case (w[23:16])
      8'h20: rd = fl[w[7:0]][7:0];
      8'h28: rd = fl[w[7:0]][15:8];
      8'ha0: rd = ee[w[3:0]];
      8'hf0: rd = {7'h00, busy > 0};
      default: rd = 8'h00;
    endcase
  endfunction
  // Writes landing while busy are lost, as on silicon
  task automatic exec(input logic [31:0] c);
    if (!en)
      en <= (c[31:16] == 16'hac53) && !skew;
    else if (busy == 0)
      case (c[31:24])
        8'hac:
          if (c[23:16] == 8'h80)
          begin
            for (int i = 0; i < 256; i++) fl[i] <= 16'hffff;
            for (int i = 0; i < 16; i++) ee[i] <= 8'hff;
            busy <= BUSY_CYC;
          end
        8'h40: pb[c[13:8]][7:0] <= c[7:0];
        8'h48: pb[c[13:8]][15:8] <= c[7:0];
        8'h4c:
        begin
          for (int i = 0; i < 64; i++) fl[{c[15:14], 6'(i)}] <= pb[i];
          busy <= BUSY_CYC;
        end
        8'hc0:
        begin
          ee[c[11:8]] <= c[7:0];
          busy <= BUSY_CYC;
        end
        8'hc1:
        begin
          eb[c[9:8]] <= c[7:0];
          ev[c[9:8]] <= 1'b1;
        end
        8'hc2:
        begin
          for (int i = 0; i < 4; i++) if (ev[i]) ee[{c[11:10], 2'(i)}] <= eb[i];
          ev <= 4'h0;
          busy <= BUSY_CYC;
        end
        default: ;
      endcase
  endtask
  // Link clock goes through two flops before edges are seen
  always @(posedge mclk)
  begin
    sy <= {sy[1:0], sck};
    if (busy > 0) busy <= busy - 1;
    if (tgt_reset_n)
    begin
      en <= 1'b0;
      n <= 5'h00;
      miso <= ~miso;
    end
    else if (fall)
    begin
      miso <= out[7];
      out <= {out[6:0], 1'b0};
    end
    else if (rise)
    begin
      sh <= x[30:0];
      n <= n + 5'h01;
      if (n[2:0] == 3'h7) out <= skew ? ~x[7:0] : x[7:0];
      if (n == 5'h17) out <= rd(x[23:0]);
      if (n == 5'h1f) exec(x);
    end
  end
endmodule // isp_tgt_model
`default_nettype wire

//--- verif/isp_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, x); end end
module isp_host_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic session = 1'b0;
  logic cmd_valid = 1'b0;
  logic [31:0] cmd_word = 32'h0;
  logic use_poll = 1'b0;
  logic skew = 1'b0;
  logic cmd_ready, rsp_valid, rsp_echo_ok, in_session, sync_fail;
  logic tgt_reset_n, tgt_sck, tgt_mosi, tgt_miso;
  logic [7:0] rsp_data, a, v, w;
  logic [15:0] d;
  logic [3:0] e;
  logic [8:0] hd;
  logic [8:0] q[$];
  logic ek[$];
  logic ex;
  int miscompares = 0;
  int n_compared = 0;
  isp_host #(.PWRUP_CYC(50), .FLASH_CYC(400), .EEPROM_CYC(800)) dut_u (.mclk(mclk),
    .rst_n(rst_n), .session(session), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .use_poll(use_poll), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_echo_ok(rsp_echo_ok), .in_session(in_session), .sync_fail(sync_fail),
    .tgt_reset_n(tgt_reset_n), .tgt_sck(tgt_sck), .tgt_mosi(tgt_mosi), .tgt_miso(tgt_miso));
  isp_tgt_model #(.BUSY_CYC(350)) tgt_u (.mclk(mclk), .tgt_reset_n(tgt_reset_n),
    .sck(tgt_sck), .mosi(tgt_mosi), .skew(skew), .miso(tgt_miso));
  always #5 mclk = ~mclk;
  task automatic wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Holds the request until taken; bit 8 of x asks for a data check
  task automatic issue(input logic [31:0] c, input logic p, input logic [8:0] x);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_word <= c;
    use_poll <= p;
    q.push_back(x);
    ek.push_back(c[23:16] == isp_pkg::OP_ENABLE_B2);
    @(posedge mclk);
    for (int k = 0; k < 30000 && cmd_ready !== 1'b1; k++) @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic wait_hi(ref logic s);
    for (int k = 0; k < 30000 && s !== 1'b1; k++) @(posedge mclk);
  endtask
  // Each answer is matched with the oldest note
  always @(posedge mclk)
  begin
    if (rsp_valid === 1'b1 && q.size() > 0)
    begin
      hd = q.pop_front();
      if (hd[8]) `CHK(rsp_data, hd[7:0])
      // The second byte comes back while the third shifts
      ex = ek.pop_front();
      `CHK(rsp_echo_ok, ex)
    end
  end
  // Stall guard, well beyond the expected run
  initial
  begin
    #500000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(54831));
    a = 8'($urandom);
    d = 16'($urandom);
    v = 8'($urandom);
    w = 8'($urandom);
    e = {1'b1, 3'($urandom)};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // First enable misses its echo, so the retry path runs
    skew <= 1'b1;
    session <= 1'b1;
    wait_hi(sync_fail);
    `CHK(in_session, 1'b0)
    skew <= 1'b0;
    wait_hi(in_session);
    `CHK(sync_fail, 1'b1)
    issue({16'hac80, 16'h0000}, 1'b0, 9'h000);
    issue({16'h2000, a, 8'h00}, 1'b0, 9'h1ff);
    issue({16'ha000, 4'h0, e, 8'h00}, 1'b0, 9'h1ff);
    // Flash page: low byte then high byte, commit, read both back
    issue({16'h4000, a, d[7:0]}, 1'b0, 9'h000);
    issue({16'h4800, a, d[15:8]}, 1'b0, 9'h000);
    issue({16'h4c00, a, 8'h00}, 1'b0, 9'h000);
    issue({16'h2000, a, 8'h00}, 1'b0, {1'b1, d[7:0]});
    issue({16'h2800, a, 8'h00}, 1'b0, {1'b1, d[15:8]});
    // EEPROM byte write with busy polling instead of the fixed wait
    issue({16'hc000, 4'h0, e, v}, 1'b1, 9'h000);
    issue(32'hf0000000, 1'b1, 9'h101);
    issue(32'hf0000000, 1'b1, 9'h100);
    issue({16'ha000, 4'h0, e, 8'h00}, 1'b0, {1'b1, v});
    // EEPROM page with one loaded byte; its neighbour must stay erased
    issue({24'hc10002, w}, 1'b0, 9'h000);
    issue(32'hc2000400, 1'b0, 9'h000);
    issue(32'ha0000600, 1'b0, {1'b1, w});
    issue(32'ha0000500, 1'b0, 9'h1ff);
    // Enable sent again inside the session must report a good echo
    issue(32'hac530000, 1'b0, 9'h000);
    for (int k = 0; k < 30000 && q.size() != 0; k++) @(posedge mclk);
    session <= 1'b0;
    wait_hi(tgt_reset_n);
    `CHK(tgt_reset_n, 1'b1)
    `CHK(in_session, 1'b0)
    wrap_up();
  end
endmodule // isp_host_tb
`default_nettype wire
